// [verilog/tmr_pkg.sv]
// package: register map, field layout, reset values and carriers of the 8-bit timer
package tmr_pkg;

	// ****************************************************
	// register addresses
	// ****************************************************
	localparam logic [7:0] TMR_ADDR_CTRL2 = 8'h3c;
	localparam logic [7:0] TMR_ADDR_CTRL1 = 8'h3d;
	localparam logic [7:0] TMR_ADDR_STAT = 8'h3e;
	localparam logic [7:0] TMR_ADDR_CAP1 = 8'h3f;
	localparam logic [7:0] TMR_ADDR_CMP1 = 8'h40;
	localparam logic [7:0] TMR_ADDR_CNT = 8'h41;
	localparam logic [7:0] TMR_ADDR_ACNT = 8'h42;
	localparam logic [7:0] TMR_ADDR_CAP2 = 8'h43;
	localparam logic [7:0] TMR_ADDR_CMP2 = 8'h44;

	// ****************************************************
	// reset values and counts
	// ****************************************************
	localparam logic [7:0] TMR_CNT_RESET = 8'hfc;
	localparam logic [7:0] TMR_CNT_MAX = 8'hff;
	localparam logic [7:0] TMR_REG_RESET = 8'h00;
	localparam logic [12:0] TMR_DIV_CPU4 = 13'h0004;
	localparam logic [12:0] TMR_DIV_CPU2 = 13'h0002;
	localparam logic [12:0] TMR_DIV_CPU8 = 13'h0008;
	localparam int unsigned TMR_OSC_DIV = 8000;

	// prescale_select encodings
	localparam logic [1:0] TMR_SEL_CPU4 = 2'h0;
	localparam logic [1:0] TMR_SEL_CPU2 = 2'h1;
	localparam logic [1:0] TMR_SEL_CPU8 = 2'h2;
	localparam logic [1:0] TMR_SEL_OSC = 2'h3;

	// status bit positions
	localparam int TMR_ST_CAPF1 = 7;
	localparam int TMR_ST_CMPF1 = 6;
	localparam int TMR_ST_OVF = 5;
	localparam int TMR_ST_CAPF2 = 4;
	localparam int TMR_ST_CMPF2 = 3;
	localparam int TMR_ST_DIS = 2;

	// ****************************************************
	// carriers
	// ****************************************************
	typedef struct packed {
		logic captureIrqEnable;
		logic compareIrqEnable;
		logic overflowIrqEnable;
		logic forceLevelTwo;
		logic forceLevelOne;
		logic outputLevelTwo;
		logic captureEdgeOne;
		logic outputLevelOne;
	} tmr_ctrl1_s;

	typedef struct packed {
		logic comparePinOneEnable;
		logic comparePinTwoEnable;
		logic singlePulseSelect;
		logic pwmSelect;
		logic [1:0] prescaleSelect;
		logic captureEdgeTwo;
		logic reserved0;
	} tmr_ctrl2_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tmr_req_s;

	typedef struct packed {
		logic levelOne;
		logic enableOne;
		logic levelTwo;
		logic enableTwo;
	} tmr_pins_s;

endpackage

// [verilog/tmr_edge_detect.sv]
// capture pin synchroniser with selectable active edge
module tmr_edge_detect (
	input wire logic clk_sys, // system clock
	input wire logic srst, // synchronous reset, active high
	input wire logic pinIn, // asynchronous capture pin
	input wire logic riseSel, // 1 rising edge, 0 falling edge
	output logic edgeEvt // one-cycle pulse on the active edge
);

	logic syncA_r, syncA_nxt;
	logic syncB_r, syncB_nxt;
	logic prev_r, prev_nxt;

	// ****************************************************
	// synchroniser and edge history
	// ****************************************************
	// only the second stage and the history flop feed the edge logic
	always_comb begin
		syncA_nxt = pinIn;
		syncB_nxt = syncA_r;
		prev_nxt = syncB_r;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			syncA_r <= 1'b0;
			syncB_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			syncA_r <= syncA_nxt;
			syncB_r <= syncB_nxt;
			prev_r <= prev_nxt;
		end
	end

	// edge pick
	assign edgeEvt = riseSel ? (syncB_r & ~prev_r) : (~syncB_r & prev_r);

endmodule

// [verilog/tmr_timer8.sv]
// 8-bit timer with two input captures, two output compares, one-pulse and pwm modes
//
// Local design decisions: the plain strobed port and the register addresses.
module tmr_timer8 #(
	parameter logic [12:0] OSC_DIV = 13'(tmr_pkg::TMR_OSC_DIV) // oscillator divider
) (
	input wire logic clk_sys, // system clock, 40 MHz
	input wire logic srst, // synchronous reset, active high
	input wire tmr_pkg::tmr_req_s busReq, // register request
	output logic [7:0] busRdata, // read data, one cycle after read strobe
	input wire logic captureInPinOne, // capture input pin one
	input wire logic captureInPinTwo, // capture input pin two
	output tmr_pkg::tmr_pins_s comparePins, // compare pin levels and enables
	output logic timerIrq // timer interrupt request, level
);
	import tmr_pkg::*;

	tmr_ctrl1_s ctrl1_r, ctrl1_nxt;
	tmr_ctrl2_s ctrl2_r, ctrl2_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [12:0] pre_r, pre_nxt;
	logic [7:0] cmp1_r, cmp1_nxt;
	logic [7:0] cmp2_r, cmp2_nxt;
	logic [7:0] cap1_r, cap1_nxt;
	logic [7:0] cap2_r, cap2_nxt;
	logic capF1_r, capF1_nxt;
	logic cmpF1_r, cmpF1_nxt;
	logic ovF_r, ovF_nxt;
	logic capF2_r, capF2_nxt;
	logic cmpF2_r, cmpF2_nxt;
	logic timerDisable_r, timerDisable_nxt;
	logic [4:0] clrArm_r, clrArm_nxt;
	logic pinLvl1_r, pinLvl1_nxt;
	logic pinLvl2_r, pinLvl2_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [12:0] divSel;
	logic tick;
	logic [7:0] cntInc;
	logic matchOne, matchTwo, wrapEvt, capEvt1, capEvt2, rawCap1;
	logic pwmMode, opmMode, cntWrite, opmStart;
	logic [7:0] statusByte;
	logic wrHit, rdHit;

	// ****************************************************
	// capture inputs
	// ****************************************************
	// pins are asynchronous, so each goes through the synchroniser first
	tmr_edge_detect capOne (
		.clk_sys(clk_sys),
		.srst(srst),
		.pinIn(captureInPinOne),
		.riseSel(ctrl1_r.captureEdgeOne),
		.edgeEvt(rawCap1)
	);

	tmr_edge_detect capTwo (
		.clk_sys(clk_sys),
		.srst(srst),
		.pinIn(captureInPinTwo),
		.riseSel(ctrl2_r.captureEdgeTwo),
		.edgeEvt(capEvt2)
	);

	// ****************************************************
	// prescaler and match decode
	// ****************************************************
	// pwm wins over single pulse when both are set; pin one input is cut off in pwm
	always_comb begin
		pwmMode = ctrl2_r.pwmSelect;
		opmMode = ctrl2_r.singlePulseSelect & ~ctrl2_r.pwmSelect;
		capEvt1 = rawCap1 & ~pwmMode;
		opmStart = capEvt1 & opmMode & ~timerDisable_r;
		wrHit = busReq.wr;
		rdHit = busReq.rd;
		cntWrite = wrHit & (busReq.addr == TMR_ADDR_CNT || busReq.addr == TMR_ADDR_ACNT);
		unique case (ctrl2_r.prescaleSelect)
			TMR_SEL_CPU4: divSel = TMR_DIV_CPU4;
			TMR_SEL_CPU2: divSel = TMR_DIV_CPU2;
			TMR_SEL_CPU8: divSel = TMR_DIV_CPU8;
			TMR_SEL_OSC: divSel = OSC_DIV;
		endcase
		// >= keeps the prescaler safe when the divider shrinks mid-count
		tick = ~timerDisable_r & (pre_r >= 13'(divSel - 13'h0001));
		cntInc = 8'(cnt_r + 8'h01);
		matchOne = tick & (cntInc == cmp1_r);
		matchTwo = tick & (cntInc == cmp2_r);
		wrapEvt = tick & (cnt_r == TMR_CNT_MAX) & ~(pwmMode & matchTwo);
	end

	// ****************************************************
	// counter and prescaler state
	// ****************************************************
	// a write to either counter address restarts count and prescaler
	always_comb begin
		pre_nxt = pre_r;
		cnt_nxt = cnt_r;
		if (cntWrite) begin
			pre_nxt = 13'h0000;
			cnt_nxt = TMR_CNT_RESET;
		end else if (timerDisable_r) begin
			pre_nxt = pre_r;
		end else if (opmStart) begin
			pre_nxt = 13'h0000;
			cnt_nxt = TMR_CNT_RESET;
		end else if (tick) begin
			pre_nxt = 13'h0000;
			if (pwmMode && matchTwo)
				cnt_nxt = TMR_CNT_RESET;
			else
				cnt_nxt = cntInc;
		end else begin
			pre_nxt = 13'(pre_r + 13'h0001);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pre_r <= 13'h0000;
			cnt_r <= TMR_CNT_RESET;
		end else begin
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// ****************************************************
	// registers, flags and read data
	// ****************************************************
	assign statusByte = {capF1_r, cmpF1_r, ovF_r, capF2_r, cmpF2_r, timerDisable_r, 2'b00};

	// flags armed by a status read are cleared by the matching access; a new event wins
	always_comb begin
		ctrl1_nxt = ctrl1_r;
		ctrl2_nxt = ctrl2_r;
		cmp1_nxt = cmp1_r;
		cmp2_nxt = cmp2_r;
		cap1_nxt = cap1_r;
		cap2_nxt = cap2_r;
		timerDisable_nxt = timerDisable_r;
		clrArm_nxt = clrArm_r;
		rdata_nxt = 8'h00;
		capF1_nxt = capF1_r;
		cmpF1_nxt = cmpF1_r;
		ovF_nxt = ovF_r;
		capF2_nxt = capF2_r;
		cmpF2_nxt = cmpF2_r;
		if (wrHit) begin
			unique case (busReq.addr)
				TMR_ADDR_CTRL1: ctrl1_nxt = busReq.wdata;
				TMR_ADDR_CTRL2: ctrl2_nxt = {busReq.wdata[7:1], 1'b0};
				TMR_ADDR_STAT: timerDisable_nxt = busReq.wdata[TMR_ST_DIS];
				TMR_ADDR_CMP1: cmp1_nxt = busReq.wdata;
				TMR_ADDR_CMP2: cmp2_nxt = busReq.wdata;
				default: ;
			endcase
		end
		if (rdHit) begin
			unique case (busReq.addr)
				TMR_ADDR_CTRL1: rdata_nxt = ctrl1_r;
				TMR_ADDR_CTRL2: rdata_nxt = ctrl2_r;
				TMR_ADDR_STAT: rdata_nxt = statusByte;
				TMR_ADDR_CAP1: rdata_nxt = cap1_r;
				TMR_ADDR_CMP1: rdata_nxt = cmp1_r;
				TMR_ADDR_CNT: rdata_nxt = cnt_r;
				TMR_ADDR_ACNT: rdata_nxt = cnt_r;
				TMR_ADDR_CAP2: rdata_nxt = cap2_r;
				TMR_ADDR_CMP2: rdata_nxt = cmp2_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
		// second step of the clear sequence, any access of the owning register
		if (rdHit || wrHit) begin
			if (busReq.addr == TMR_ADDR_CAP1 && clrArm_r[4]) begin
				capF1_nxt = 1'b0;
				clrArm_nxt[4] = 1'b0;
			end
			if (busReq.addr == TMR_ADDR_CMP1 && clrArm_r[3]) begin
				cmpF1_nxt = 1'b0;
				clrArm_nxt[3] = 1'b0;
			end
			if (busReq.addr == TMR_ADDR_CNT && clrArm_r[2]) begin
				ovF_nxt = 1'b0;
				clrArm_nxt[2] = 1'b0;
			end
			if (busReq.addr == TMR_ADDR_CAP2 && clrArm_r[1]) begin
				capF2_nxt = 1'b0;
				clrArm_nxt[1] = 1'b0;
			end
			if (busReq.addr == TMR_ADDR_CMP2 && clrArm_r[0]) begin
				cmpF2_nxt = 1'b0;
				clrArm_nxt[0] = 1'b0;
			end
		end
		// first step: a status read arms only the flags seen set
		if (rdHit && busReq.addr == TMR_ADDR_STAT)
			clrArm_nxt = {capF1_r, cmpF1_r, ovF_r, capF2_r, cmpF2_r};
		// hardware events, placed last so a set wins over a clear
		if (capEvt1) begin
			cap1_nxt = cnt_r;
			capF1_nxt = 1'b1;
		end
		if (pwmMode && matchTwo)
			capF1_nxt = 1'b1;
		if (capEvt2) begin
			cap2_nxt = cnt_r;
			capF2_nxt = 1'b1;
		end
		// compare flags stay quiet in pwm mode
		if (matchOne && !pwmMode)
			cmpF1_nxt = 1'b1;
		if (matchTwo && !pwmMode)
			cmpF2_nxt = 1'b1;
		if (wrapEvt)
			ovF_nxt = 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl1_r <= TMR_REG_RESET;
			ctrl2_r <= TMR_REG_RESET;
			cmp1_r <= TMR_REG_RESET;
			cmp2_r <= TMR_REG_RESET;
			cap1_r <= TMR_REG_RESET;
			cap2_r <= TMR_REG_RESET;
			timerDisable_r <= 1'b0;
			clrArm_r <= 5'h00;
			rdata_r <= 8'h00;
			capF1_r <= 1'b0;
			cmpF1_r <= 1'b0;
			ovF_r <= 1'b0;
			capF2_r <= 1'b0;
			cmpF2_r <= 1'b0;
		end else begin
			ctrl1_r <= ctrl1_nxt;
			ctrl2_r <= ctrl2_nxt;
			cmp1_r <= cmp1_nxt;
			cmp2_r <= cmp2_nxt;
			cap1_r <= cap1_nxt;
			cap2_r <= cap2_nxt;
			timerDisable_r <= timerDisable_nxt;
			clrArm_r <= clrArm_nxt;
			rdata_r <= rdata_nxt;
			capF1_r <= capF1_nxt;
			cmpF1_r <= cmpF1_nxt;
			ovF_r <= ovF_nxt;
			capF2_r <= capF2_nxt;
			cmpF2_r <= cmpF2_nxt;
		end
	end

	// ****************************************************
	// compare pin levels
	// ****************************************************
	// forces act on the control write itself, later matches may override
	always_comb begin
		pinLvl1_nxt = pinLvl1_r;
		pinLvl2_nxt = pinLvl2_r;
		if (pwmMode) begin
			if (matchTwo)
				pinLvl1_nxt = ctrl1_r.outputLevelTwo;
			else if (matchOne)
				pinLvl1_nxt = ctrl1_r.outputLevelOne;
		end else if (opmMode) begin
			if (opmStart)
				pinLvl1_nxt = ctrl1_r.outputLevelTwo;
			else if (matchOne)
				pinLvl1_nxt = ctrl1_r.outputLevelOne;
		end else begin
			if (matchOne)
				pinLvl1_nxt = ctrl1_r.outputLevelOne;
			if (matchTwo)
				pinLvl2_nxt = ctrl1_r.outputLevelTwo;
		end
		if (wrHit && busReq.addr == TMR_ADDR_CTRL1) begin
			if (busReq.wdata[3] && ctrl2_r.comparePinOneEnable)
				pinLvl1_nxt = busReq.wdata[0];
			if (busReq.wdata[4] && ctrl2_r.comparePinTwoEnable)
				pinLvl2_nxt = busReq.wdata[2];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pinLvl1_r <= 1'b0;
			pinLvl2_r <= 1'b0;
		end else begin
			pinLvl1_r <= pinLvl1_nxt;
			pinLvl2_r <= pinLvl2_nxt;
		end
	end

	// ****************************************************
	// outputs
	// ****************************************************
	// with the enable low the port pin belongs to general i/o, level then reads zero
	assign comparePins.enableOne = ctrl2_r.comparePinOneEnable & ~timerDisable_r;
	assign comparePins.enableTwo = ctrl2_r.comparePinTwoEnable & ~timerDisable_r;
	assign comparePins.levelOne = pinLvl1_r & comparePins.enableOne;
	assign comparePins.levelTwo = pinLvl2_r & comparePins.enableTwo;
	assign busRdata = rdata_r;
	assign timerIrq = (ctrl1_r.overflowIrqEnable & ovF_r)
		| (ctrl1_r.captureIrqEnable & (capF1_r | capF2_r))
		| (ctrl1_r.compareIrqEnable & (cmpF1_r | cmpF2_r));

	// ****************************************************
	// assertions
	// ****************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	overflow_irq_a: assert property (ovF_r && ctrl1_r.overflowIrqEnable |-> timerIrq)
		else $error("overflow flag enabled but no interrupt");
	wrap_flag_a: assert property (tick && cnt_r == 8'hff && !pwmMode && !cntWrite && !opmStart |=> ovF_r && cnt_r == 8'h00)
		else $error("wrap did not set overflow flag");
	freeze_count_a: assert property (timerDisable_r && !cntWrite |=> $stable(cnt_r))
		else $error("counter moved while disabled");
	disable_pins_a: assert property (timerDisable_r |-> !comparePins.enableOne && !comparePins.enableTwo)
		else $error("compare pin enabled while timer disabled");
	cnt_restart_a: assert property (cntWrite |=> cnt_r == 8'hfc)
		else $error("counter write did not restart at fc");
	alias_keep_ovf_a: assert property ((busReq.rd || busReq.wr) && busReq.addr == TMR_ADDR_ACNT && ovF_r |=> ovF_r)
		else $error("alias counter access cleared overflow flag");
	capture_copy_a: assert property (capEvt2 |=> cap2_r == $past(cnt_r) && capF2_r)
		else $error("capture two did not copy the counter");
	pwm_reload_a: assert property (pwmMode && matchTwo && !cntWrite |=> cnt_r == 8'hfc && capF1_r)
		else $error("pwm period did not reload counter");
	count_step_a: assert property (tick && !cntWrite && !opmStart && !(pwmMode && matchTwo) |=> cnt_r == 8'($past(cnt_r) + 8'h01))
		else $error("counter did not step by one");
	force_one_a: assert property (busReq.wr && busReq.addr == TMR_ADDR_CTRL1 && busReq.wdata[3] && ctrl2_r.comparePinOneEnable |=> pinLvl1_r == $past(busReq.wdata[0]))
		else $error("force level one not applied");
	read_clear_a: assert property ((busReq.rd || busReq.wr) && busReq.addr == TMR_ADDR_CMP1 && clrArm_r[3] && !(matchOne && !pwmMode) |=> !cmpF1_r)
		else $error("compare flag one not cleared by sequence");

endmodule

// [sim/tmr_pin_partner.sv]
// partner model: capture pin sources and a load that watches compare pin one
module tmr_pin_partner (
	input wire logic clk_sys, // system clock
	input wire tmr_pkg::tmr_pins_s comparePins, // compare pins from the timer
	output logic captureInPinOne, // capture source one
	output logic captureInPinTwo, // capture source two
	output int risesOne // rising edges seen on driven pin one
);
	timeunit 1ns;
	timeprecision 1ps;
	import tmr_pkg::*;
	logic lastOne;

	// sources start low on one and high on two so either active edge can be made
	initial begin
		captureInPinOne = 1'b0;
		captureInPinTwo = 1'b1;
		risesOne = 0;
		lastOne = 1'b0;
	end

	// a released pin reads low here, so only a driven high level counts
	always @(posedge clk_sys) begin
		lastOne <= comparePins.levelOne & comparePins.enableOne;
		if (comparePins.levelOne && comparePins.enableOne && !lastOne) begin
			risesOne <= risesOne + 1;
		end
	end

	// pin changes land just after a clock edge
	task automatic setOne(input logic v);
		@(posedge clk_sys);
		captureInPinOne <= v;
	endtask

	task automatic setTwo(input logic v);
		@(posedge clk_sys);
		captureInPinTwo <= v;
	endtask
endmodule

// [sim/tb_tmr_timer8.sv]
// testbench of the 8-bit capture/compare timer
module tb_tmr_timer8;
	timeunit 1ns;
	timeprecision 1ps;
	import tmr_pkg::*;
	localparam int OSC = 16;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	tmr_req_s busReq = '0;
	logic [7:0] busRdata;
	logic captureInPinOne;
	logic captureInPinTwo;
	tmr_pins_s comparePins;
	logic timerIrq;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	int divs[4] = '{4, 2, 8, OSC};
	int mCnt;
	int n;
	int rises;
	logic [7:0] rdv;

	always #12.5 clk_sys = ~clk_sys;

	tmr_timer8 #(.OSC_DIV(13'(OSC))) dut (.clk_sys(clk_sys), .srst(srst), .busReq(busReq),
		.busRdata(busRdata), .captureInPinOne(captureInPinOne),
		.captureInPinTwo(captureInPinTwo), .comparePins(comparePins), .timerIrq(timerIrq));

	tmr_pin_partner partner (.clk_sys(clk_sys), .comparePins(comparePins),
		.captureInPinOne(captureInPinOne), .captureInPinTwo(captureInPinTwo),
		.risesOne(rises));

	// *********************************
	// bus and compare tasks
	// *********************************
	// every access leaves one idle cycle, so no strobe is assigned twice in a step
	task automatic busOp(input logic [7:0] a, input logic [7:0] d, input logic w);
		busReq <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge clk_sys);
		busReq <= '0;
		@(posedge clk_sys);
		rdv = busRdata;
	endtask

	task automatic chkVal(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t value %h expected %h", $time, g, e);
		end
	endtask

	task automatic chkReg(input logic [7:0] a, input logic [7:0] e);
		busOp(a, 8'h00, 1'b0);
		chkVal(rdv, e);
	endtask

	// compares {irq, pins} as seen at the current edge
	task automatic chkOut(input logic [4:0] e);
		total_checks++;
		if ({timerIrq, comparePins} !== e) begin
			failures++;
			$display("[FAIL] %0t outputs %b expected %b", $time, {timerIrq, comparePins}, e);
		end
	endtask

	task automatic idle(input int k);
		repeat (k) @(posedge clk_sys);
	endtask

	// enable for exactly k prescaled ticks, then freeze; the model follows
	task automatic run(input int k, input int d);
		busOp(TMR_ADDR_STAT, 8'h00, 1'b1);
		idle(k * d - 1);
		busOp(TMR_ADDR_STAT, 8'h04, 1'b1);
		mCnt = (mCnt + k) % 256;
	endtask

	task automatic restart();
		busOp(TMR_ADDR_CNT, 8'(n), 1'b1);
		mCnt = 252;
	endtask

	task automatic print_verdict();
		if (failures == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// a hang is cut short well beyond the several hundred cycles the run needs
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	// *********************************
	// main sequence
	// *********************************
	initial begin
		void'($urandom(32'h22815f30));
		n = 0;
		repeat (4) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		chkReg(TMR_ADDR_CNT, TMR_CNT_RESET);
		chkReg(TMR_ADDR_STAT, 8'h00);
		chkReg(TMR_ADDR_CTRL2, 8'h00);
		chkReg(TMR_ADDR_CMP1, 8'h00);
		chkReg(TMR_ADDR_CMP2, 8'h00);
		busOp(TMR_ADDR_STAT, 8'h04, 1'b1);
		restart();
		chkReg(TMR_ADDR_CNT, 8'(mCnt));
		idle(40);
		chkReg(TMR_ADDR_ACNT, 8'(mCnt));
		busOp(8'h45, 8'hff, 1'b1);
		chkReg(8'h45, 8'h00);
		n = $urandom;
		busOp(TMR_ADDR_CMP1, 8'(n), 1'b1);
		chkReg(TMR_ADDR_CMP1, 8'(n));
		// every prescaler choice, random tick counts of 3 to 9 from fc, so four or more wrap past ff
		for (int s = 0; s < 4; s++) begin
			busOp(TMR_ADDR_CTRL2, {4'h0, 2'(s), 2'b00}, 1'b1);
			restart();
			run($urandom_range(3, 9), divs[s]);
			chkReg(TMR_ADDR_CNT, 8'(mCnt));
		end
		// matches on both compares plus a wrap, then the clear sequences
		busOp(TMR_ADDR_CMP1, 8'hfe, 1'b1);
		busOp(TMR_ADDR_CMP2, 8'h01, 1'b1);
		busOp(TMR_ADDR_CTRL1, 8'h25, 1'b1);
		busOp(TMR_ADDR_CTRL2, 8'hc4, 1'b1);
		restart();
		run(6, 2);
		chkOut(5'b10000);
		chkReg(TMR_ADDR_STAT, 8'h6c);
		for (int i = 0; i < 3; i++) begin
			busOp(TMR_ADDR_CTRL1, 8'h20 << i, 1'b1);
			chkOut({i < 2, 4'b0000});
		end
		chkReg(TMR_ADDR_ACNT, 8'(mCnt));
		chkReg(TMR_ADDR_STAT, 8'h6c);
		chkReg(TMR_ADDR_CNT, 8'(mCnt));
		chkReg(TMR_ADDR_CMP1, 8'hfe);
		busOp(TMR_ADDR_CMP2, 8'h01, 1'b1);
		chkReg(TMR_ADDR_STAT, 8'h04);
		busOp(TMR_ADDR_STAT, 8'h00, 1'b1);
		chkOut(5'b01111);
		busOp(TMR_ADDR_CTRL1, 8'h18, 1'b1);
		chkOut(5'b00101);
		busOp(TMR_ADDR_CTRL2, 8'h44, 1'b1);
		busOp(TMR_ADDR_CTRL1, 8'h1d, 1'b1);
		chkOut(5'b00011);
		// captures on chosen edges, then an edge of the wrong sense
		busOp(TMR_ADDR_STAT, 8'h04, 1'b1);
		busOp(TMR_ADDR_CMP1, 8'h80, 1'b1);
		busOp(TMR_ADDR_CMP2, 8'h80, 1'b1);
		busOp(TMR_ADDR_CTRL1, 8'h02, 1'b1);
		busOp(TMR_ADDR_CTRL2, 8'hc4, 1'b1);
		restart();
		run($urandom_range(1, 3), 2);
		partner.setOne(1'b1);
		partner.setTwo(1'b0);
		idle(8);
		chkReg(TMR_ADDR_STAT, 8'h94);
		chkReg(TMR_ADDR_CAP1, 8'(mCnt));
		chkReg(TMR_ADDR_CAP2, 8'(mCnt));
		partner.setOne(1'b0);
		idle(8);
		chkReg(TMR_ADDR_STAT, 8'h04);
		// pwm: period of six ticks from the reload to the compare two match
		busOp(TMR_ADDR_CMP1, 8'h00, 1'b1);
		busOp(TMR_ADDR_CMP2, 8'h02, 1'b1);
		busOp(TMR_ADDR_CTRL1, 8'h04, 1'b1);
		busOp(TMR_ADDR_CTRL2, 8'hd4, 1'b1);
		restart();
		busOp(TMR_ADDR_STAT, 8'h00, 1'b1);
		idle(30);
		n = rises;
		idle(120);
		chkVal(8'(rises - n), 8'd10);
		busOp(TMR_ADDR_STAT, 8'h04, 1'b1);
		chkReg(TMR_ADDR_STAT, 8'ha4);
		// one pulse started by a rising edge on capture one
		busOp(TMR_ADDR_CTRL2, 8'ha4, 1'b1);
		busOp(TMR_ADDR_CTRL1, 8'h06, 1'b1);
		busOp(TMR_ADDR_STAT, 8'h00, 1'b1);
		partner.setOne(1'b1);
		idle(6);
		chkOut(5'b01100);
		idle(12);
		chkOut(5'b00100);
		print_verdict();
	end
endmodule
